// >>> hdl/sos_defines.svh
// Widths, counts and key values of the switching output stage.
`ifndef SOS_DEFINES_SVH
`define SOS_DEFINES_SVH
`define SOS_NCH 4
`define SOS_NFLT 8
`define SOS_NPAIR 8
`define SOS_ON_W 19
`define SOS_FRAC_W 4
`define SOS_PER_W 15
`define SOS_DLY_W 16
`define SOS_STEP_W 16
`define SOS_LEN_W 18
`define SOS_SRC_W 128
`define SOS_SEL_W 7
`define SOS_PSEL_W 3
`define SOS_GAP_W 8
`define SOS_KEY_W 32
`define SOS_UNLOCK_KEY 32'h13579BDF
`define SOS_GAP_MAX 8'hFF
`define SOS_GAP_ONE 8'h01
`define SOS_LEN_ONE 18'h00001
`define SOS_FRAC_ONE 5'h01
`endif

// >>> hdl/sos_pkg.sv
// Types shared by the switching output stage.
package sos_pkg;
`include "sos_defines.svh"

  typedef enum logic [1:0] {
    SOS_IDLE = 2'b00,
    SOS_WAIT = 2'b01,
    SOS_RUN = 2'b11
  } sos_state_t;

  typedef struct packed {
    logic [`SOS_ON_W-1:0] on_dur;
    logic [`SOS_PER_W-1:0] cyc_len;
    logic [`SOS_DLY_W-1:0] start_dly;
    logic signed [`SOS_STEP_W-1:0] shift;
    logic half_duty;
  } sos_chan_prm_t;

  typedef struct packed {
    logic en;
    logic [`SOS_SEL_W-1:0] src_sel;
    logic filt_en;
    logic [`SOS_GAP_W-1:0] filt_width;
    logic flip;
    logic sticky;
  } sos_fault_cfg_t;

  typedef struct packed {
    logic [`SOS_PSEL_W-1:0] pair_sel;
    logic out_en;
    logic hi_force_val;
    logic lo_force_val;
    logic hi_force_sel;
    logic lo_force_sel;
    logic [`SOS_GAP_W-1:0] min_gap;
    logic [`SOS_NFLT-1:0] fault_gate;
    logic hi_export;
    logic lo_export;
  } sos_drv_cfg_t;

  typedef struct packed {
    logic guard_off;
    logic swap;
    logic hi_flip;
    logic lo_flip;
  } sos_guard_t;

endpackage : sos_pkg

// >>> hdl/sos_top.sv
// Switching output stage: pulse channels, fault channels and pair drivers.
// ----------------------------------------------------------------------
// What this block does
// - On-time holds fifteen integer bits and four fraction bits in ticks.
// - One enable bit per channel in one word starts channels together.
// - Fraction f gives f long cycles in every sixteen cycles.
// - Dithering runs whenever the fraction nibble is non-zero.
// - Period is a plain fifteen-bit tick count.
// - A started channel waits its start delay before the first pulse.
// - A phase step stretches exactly one period to T plus the step.
// - In half-duty mode the stretched cycle stays at fifty percent.
// - Otherwise the signed step adds to on-time for that one cycle.
// - Idle channels without pending load take writes directly.
// - Running channels take writes into shadow copies only.
// - Setting the load bit raises the pending flag.
// - Shadows copy over together at the next cycle start, clearing pending.
// - Clearing load while pending cancels the transfer.
// - Eight fault channels each pick one source bus signal.
// - Each hardware fault hold is sticky or transparent.
// - The readable fault flag is always sticky.
// - A fault clear resets both hold and flag.
// - Four pair selectors pick pulse channels or event timers.
// - Force bits replace the selected pair outputs.
// - An enabled fault turns both outputs off.
// - Guarded pairs never overlap and keep the minimum gap.
// - Guarded settings change only under the unlock key.
// ----------------------------------------------------------------------
`timescale 1ns/1ps
`include "sos_defines.svh"
module sos_top
  import sos_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [`SOS_NCH-1:0] chan_enable,
  input wire logic [`SOS_NCH-1:0] chan_load,
  input wire logic [`SOS_NCH-1:0] prm_wr,
  input wire sos_chan_prm_t prm_wdata,
  input wire logic [`SOS_NCH-1:0] shift_go,
  input wire logic [`SOS_SRC_W-1:0] fault_src,
  input wire sos_fault_cfg_t [`SOS_NFLT-1:0] fault_cfg,
  input wire logic [`SOS_NFLT-1:0] fault_latch_clear,
  input wire logic [`SOS_NCH-1:0] event_timer_high,
  input wire logic [`SOS_NCH-1:0] event_timer_low,
  input wire sos_drv_cfg_t [`SOS_NCH-1:0] drv_cfg,
  input wire logic key_wr,
  input wire logic [`SOS_KEY_W-1:0] key_wdata,
  input wire logic [`SOS_NCH-1:0] guard_wr,
  input wire sos_guard_t guard_wdata,
  input wire logic [`SOS_NCH-1:0] overlap_event_clear,
  output logic [`SOS_NCH-1:0] high_side,
  output logic [`SOS_NCH-1:0] low_side,
  output logic [`SOS_NCH-1:0] commit_pending_flag,
  output logic [`SOS_NFLT-1:0] fault_live_state,
  output logic [`SOS_NFLT-1:0] fault_sticky_flag,
  output logic [`SOS_NCH-1:0] overlap_event_flag,
  output sos_guard_t [`SOS_NCH-1:0] guarded_pair_settings
);

  // ----------------------------------------------------------------------
  // Cycle arithmetic.
  // ----------------------------------------------------------------------
  function automatic logic [`SOS_LEN_W-1:0] cycle_len(input sos_chan_prm_t p, input logic step);
    logic signed [`SOS_LEN_W+1:0] t;
    t = $signed({5'h00, p.cyc_len});
    if (step) begin
      t = t + (`SOS_LEN_W+2)'(p.shift);
    end
    if (t < $signed({2'b00, `SOS_LEN_ONE})) begin
      t = $signed({2'b00, `SOS_LEN_ONE});
    end
    return t[`SOS_LEN_W-1:0];
  endfunction : cycle_len

  function automatic logic [`SOS_LEN_W-1:0] cycle_on(input sos_chan_prm_t p, input logic step,
                                                     input logic carry);
    logic signed [`SOS_LEN_W+1:0] t;
    logic [`SOS_LEN_W-1:0] len;
    len = cycle_len(p, step);
    t = $signed({5'h00, p.on_dur[`SOS_ON_W-1:`SOS_FRAC_W]}) + $signed({19'h00000, carry});
    if (step && p.half_duty) begin
      t = $signed({3'b000, len[`SOS_LEN_W-1:1]});
    end else if (step) begin
      t = t + (`SOS_LEN_W+2)'(p.shift);
    end
    if (t < 0) begin
      t = '0;
    end
    return t[`SOS_LEN_W-1:0];
  endfunction : cycle_on

  // ----------------------------------------------------------------------
  // Pulse channels.
  // ----------------------------------------------------------------------
  logic [`SOS_NCH-1:0] pwm_hi_q;
  logic [`SOS_NCH-1:0] pwm_lo_q;
  logic [`SOS_NCH-1:0] pend_q;

  for (genvar c = 0; c < `SOS_NCH; c++) begin : g_ch
    sos_chan_prm_t shd_q;
    sos_chan_prm_t wrk_q;
    sos_chan_prm_t use_prm;
    sos_state_t st_q;
    sos_state_t st_d;
    logic en_q;
    logic load_q;
    logic step_q;
    logic [`SOS_FRAC_W-1:0] acc_q;
    logic [`SOS_LEN_W-1:0] cnt_q;
    logic [`SOS_LEN_W-1:0] len_q;
    logic [`SOS_LEN_W-1:0] on_q;
    logic [`SOS_FRAC_W:0] acc_sum;
    wire en_rise = chan_enable[c] & ~en_q;
    wire load_rise = chan_load[c] & ~load_q;
    wire load_fall = ~chan_load[c] & load_q;
    wire direct_wr = prm_wr[c] & ~chan_enable[c] & ~pend_q[c];
    wire cyc_end = (st_q == SOS_RUN) && (cnt_q + `SOS_LEN_ONE >= len_q);
    wire go_run = (st_q == SOS_WAIT) && (cnt_q >= {2'b00, wrk_q.start_dly});
    wire new_cyc = cyc_end | go_run;
    wire xfer = new_cyc & pend_q[c] & ~load_fall;
    wire step_now = step_q | shift_go[c];
    assign use_prm = xfer ? shd_q : wrk_q;
    assign acc_sum = {1'b0, acc_q} + {1'b0, use_prm.on_dur[`SOS_FRAC_W-1:0]};
    wire [`SOS_LEN_W-1:0] len_nx = cycle_len(use_prm, step_now);
    wire [`SOS_LEN_W-1:0] on_nx = cycle_on(use_prm, step_now, acc_sum[`SOS_FRAC_W]);
    wire pend_d = load_rise | (pend_q[c] & ~xfer & ~load_fall);
    wire pulse_hi = (st_q == SOS_RUN) && (cnt_q < on_q);

    always_comb begin
      st_d = st_q;
      unique case (st_q)
        SOS_IDLE: begin
          if (en_rise) begin
            st_d = SOS_WAIT;
          end
        end
        SOS_WAIT: begin
          if (go_run) begin
            st_d = SOS_RUN;
          end
        end
        SOS_RUN: begin
          st_d = SOS_RUN;
        end
        default: begin
          st_d = SOS_IDLE;
        end
      endcase
      if (!chan_enable[c]) begin
        st_d = SOS_IDLE;
      end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
        st_q <= SOS_IDLE;
        en_q <= 1'b0;
        load_q <= 1'b0;
        pend_q[c] <= 1'b0;
        step_q <= 1'b0;
        shd_q <= '0;
        wrk_q <= '0;
        acc_q <= '0;
        cnt_q <= '0;
        len_q <= '0;
        on_q <= '0;
        pwm_hi_q[c] <= 1'b0;
        pwm_lo_q[c] <= 1'b0;
      end else begin
        st_q <= st_d;
        en_q <= chan_enable[c];
        load_q <= chan_load[c];
        pend_q[c] <= pend_d;
        step_q <= step_now & ~new_cyc;
        pwm_hi_q[c] <= pulse_hi;
        pwm_lo_q[c] <= (st_q == SOS_RUN) & ~pulse_hi;
        if (prm_wr[c]) begin
          shd_q <= prm_wdata;
        end
        if (direct_wr) begin
          wrk_q <= prm_wdata;
        end else if (xfer) begin
          wrk_q <= shd_q;
        end
        if (st_d != SOS_RUN || st_q != SOS_RUN) begin
          cnt_q <= '0;
        end else if (cyc_end) begin
          cnt_q <= '0;
        end else begin
          cnt_q <= cnt_q + `SOS_LEN_ONE;
        end
        if (st_q == SOS_WAIT && !go_run) begin
          cnt_q <= cnt_q + `SOS_LEN_ONE;
        end
        if (st_q == SOS_IDLE) begin
          acc_q <= '0;
        end else if (new_cyc) begin
          acc_q <= acc_sum[`SOS_FRAC_W-1:0];
          len_q <= len_nx;
          on_q <= on_nx;
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Fault source synchroniser.
  // ----------------------------------------------------------------------
  logic [`SOS_SRC_W-1:0] src_s1_q;
  logic [`SOS_SRC_W-1:0] src_s2_q;
  logic [`SOS_SRC_W-1:0] src_s3_q;
  logic [`SOS_SRC_W-1:0] src_q;
  wire [`SOS_SRC_W-1:0] src_d = (src_s2_q & src_s3_q) | (src_q & (src_s2_q | src_s3_q));

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      src_s1_q <= '0;
      src_s2_q <= '0;
      src_s3_q <= '0;
      src_q <= '0;
    end else begin
      src_s1_q <= fault_src;
      src_s2_q <= src_s1_q;
      src_s3_q <= src_s2_q;
      src_q <= src_d;
    end
  end

  // ----------------------------------------------------------------------
  // Fault channels.
  // ----------------------------------------------------------------------
  logic [`SOS_NFLT-1:0] hold_q;
  logic [`SOS_NFLT-1:0] live_q;
  logic [`SOS_NFLT-1:0] flag_q;

  for (genvar f = 0; f < `SOS_NFLT; f++) begin : g_flt
    logic filt_q;
    logic [`SOS_GAP_W-1:0] fcnt_q;
    wire raw = src_q[fault_cfg[f].src_sel];
    wire settle = (fcnt_q + `SOS_GAP_ONE >= fault_cfg[f].filt_width);
    wire clean = fault_cfg[f].filt_en ? filt_q : raw;
    wire sig = fault_cfg[f].en & (clean ^ fault_cfg[f].flip);
    wire clr = fault_latch_clear[f];
    wire hold_d = fault_cfg[f].sticky ? (sig | (hold_q[f] & ~clr)) : sig;
    wire flag_d = sig | (flag_q[f] & ~clr);

    always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
        filt_q <= 1'b0;
        fcnt_q <= '0;
        hold_q[f] <= 1'b0;
        live_q[f] <= 1'b0;
        flag_q[f] <= 1'b0;
      end else begin
        if (raw == filt_q) begin
          fcnt_q <= '0;
        end else if (settle) begin
          filt_q <= raw;
          fcnt_q <= '0;
        end else begin
          fcnt_q <= fcnt_q + `SOS_GAP_ONE;
        end
        hold_q[f] <= hold_d;
        live_q[f] <= sig;
        flag_q[f] <= flag_d;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Pair processors.
  // ----------------------------------------------------------------------
  logic [`SOS_KEY_W-1:0] key_q;
  logic [`SOS_NCH-1:0] ovl_q;
  logic [`SOS_NCH-1:0] pin_hi_q;
  logic [`SOS_NCH-1:0] pin_lo_q;
  sos_guard_t [`SOS_NCH-1:0] guard_q;
  wire [`SOS_NPAIR-1:0] all_hi = {event_timer_high, pwm_hi_q};
  wire [`SOS_NPAIR-1:0] all_lo = {event_timer_low, pwm_lo_q};
  wire unlocked = (key_q == `SOS_UNLOCK_KEY);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      key_q <= '0;
    end else if (key_wr) begin
      key_q <= key_wdata;
    end
  end

  for (genvar d = 0; d < `SOS_NCH; d++) begin : g_drv
    logic ah_q;
    logic al_q;
    logic [`SOS_GAP_W-1:0] gap_q;
    wire sel_hi = all_hi[drv_cfg[d].pair_sel];
    wire sel_lo = all_lo[drv_cfg[d].pair_sel];
    wire fh = drv_cfg[d].hi_force_sel ? drv_cfg[d].hi_force_val : sel_hi;
    wire fl = drv_cfg[d].lo_force_sel ? drv_cfg[d].lo_force_val : sel_lo;
    wire trip = |(hold_q & drv_cfg[d].fault_gate);
    wire rh = fh & ~trip;
    wire rl = fl & ~trip;
    wire prot = ~guard_q[d].guard_off;
    wire gap_ok = (gap_q >= drv_cfg[d].min_gap);
    wire ah_d = prot ? (rh & ~rl & (ah_q | (~al_q & gap_ok))) : rh;
    wire al_d = prot ? (rl & ~rh & (al_q | (~ah_q & gap_ok))) : rl;
    wire [`SOS_GAP_W-1:0] gap_d = (ah_q | al_q) ? '0 :
                                  (gap_q == `SOS_GAP_MAX) ? gap_q : gap_q + `SOS_GAP_ONE;
    wire sw_hi = guard_q[d].swap ? al_q : ah_q;
    wire sw_lo = guard_q[d].swap ? ah_q : al_q;
    wire hi_d = drv_cfg[d].out_en & drv_cfg[d].hi_export & (sw_hi ^ guard_q[d].hi_flip);
    wire lo_d = drv_cfg[d].out_en & drv_cfg[d].lo_export & (sw_lo ^ guard_q[d].lo_flip);
    wire ovl_d = (prot & rh & rl) | (ovl_q[d] & ~overlap_event_clear[d]);

    always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
        ah_q <= 1'b0;
        al_q <= 1'b0;
        gap_q <= '0;
        ovl_q[d] <= 1'b0;
        pin_hi_q[d] <= 1'b0;
        pin_lo_q[d] <= 1'b0;
        guard_q[d] <= '0;
      end else begin
        ah_q <= ah_d;
        al_q <= al_d;
        gap_q <= gap_d;
        ovl_q[d] <= ovl_d;
        pin_hi_q[d] <= hi_d;
        pin_lo_q[d] <= lo_d;
        if (guard_wr[d] && unlocked) begin
          guard_q[d] <= guard_wdata;
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Outputs.
  // ----------------------------------------------------------------------
  assign high_side = pin_hi_q;
  assign low_side = pin_lo_q;
  assign commit_pending_flag = pend_q;
  assign fault_live_state = live_q;
  assign fault_sticky_flag = flag_q;
  assign overlap_event_flag = ovl_q;
  assign guarded_pair_settings = guard_q;

endmodule : sos_top

// >>> sim/sos_top_assertions.sv
// Concurrent checks on the ports of the switching output stage.
`timescale 1ns/1ps
`include "sos_defines.svh"
module sos_chk
  import sos_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [`SOS_NCH-1:0] chan_load,
  input wire logic key_wr,
  input wire logic [`SOS_KEY_W-1:0] key_wdata,
  input wire logic [`SOS_NCH-1:0] guard_wr,
  input wire sos_guard_t guard_wdata,
  input wire logic [`SOS_NFLT-1:0] fault_latch_clear,
  input wire sos_drv_cfg_t [`SOS_NCH-1:0] drv_cfg,
  input wire logic [`SOS_NCH-1:0] high_side,
  input wire logic [`SOS_NCH-1:0] low_side,
  input wire logic [`SOS_NCH-1:0] commit_pending_flag,
  input wire logic [`SOS_NFLT-1:0] fault_live_state,
  input wire logic [`SOS_NFLT-1:0] fault_sticky_flag,
  input wire sos_guard_t [`SOS_NCH-1:0] guarded_pair_settings
);
  logic [`SOS_KEY_W-1:0] key_q;
  logic prot_w;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  assign prot_w = guarded_pair_settings[0] == 4'h0;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) key_q <= '0;
    else if (key_wr) key_q <= key_wdata;
  end
  pend_set_a: assert property ($rose(chan_load[0]) |-> ##[1:2] commit_pending_flag[0])
    else $error("pending flag not raised");
  pend_drop_a: assert property ($fell(chan_load[0]) |-> ##[1:2] !commit_pending_flag[0])
    else $error("pending flag not cancelled");
  no_overlap_a: assert property (prot_w |-> !(high_side[0] && low_side[0]))
    else $error("both pair outputs on");
  dead_gap_a: assert property (prot_w && drv_cfg[0].min_gap != 8'h00 && $fell(high_side[0]) |-> !low_side[0] [*2])
    else $error("gap after high side too short");
  key_lock_a: assert property (guard_wr[0] && key_q != `SOS_UNLOCK_KEY |=> $stable(guarded_pair_settings[0]))
    else $error("guarded settings changed while locked");
  key_open_a: assert property (guard_wr[0] && key_q == `SOS_UNLOCK_KEY |=> guarded_pair_settings[0] == $past(guard_wdata))
    else $error("guarded settings not taken under key");
  flag_hold_a: assert property (fault_sticky_flag[0] && !fault_latch_clear[0] && !$past(fault_latch_clear[0]) |=> fault_sticky_flag[0])
    else $error("fault flag dropped without clear");
  flag_clear_a: assert property (fault_latch_clear[0] && !fault_live_state[0] && !$past(fault_live_state[0]) |-> ##[1:2] !fault_sticky_flag[0])
    else $error("fault flag not cleared");
  cover property ($fell(commit_pending_flag[0]));
  cover property (guard_wr[0] && key_q == `SOS_UNLOCK_KEY);
  cover property ($rose(fault_sticky_flag[0]));
endmodule : sos_chk

bind sos_top sos_chk chk_u (.clk_sys, .rst_n, .chan_load, .key_wr, .key_wdata, .guard_wr, .guard_wdata,
  .fault_latch_clear, .drv_cfg, .high_side, .low_side, .commit_pending_flag, .fault_live_state,
  .fault_sticky_flag, .guarded_pair_settings);

// >>> sim/sos_gate_drv.sv
// Gate driver model that records shoot-through on its pins.
`timescale 1ns/1ps
`include "sos_defines.svh"
module sos_gate_drv
  import sos_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [`SOS_NCH-1:0] high_side,
  input wire logic [`SOS_NCH-1:0] low_side,
  output logic [`SOS_NCH-1:0] shoot_seen
);
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) shoot_seen <= '0;
    else shoot_seen <= shoot_seen | (high_side & low_side);
  end
endmodule : sos_gate_drv

// >>> sim/tb_top.sv
// Self-checking bench for the switching output stage.
`timescale 1ns/1ps
`include "sos_defines.svh"
module tb_top
  import sos_pkg::*;
;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [`SOS_NCH-1:0] chan_enable = '0, chan_load = '0, prm_wr = '0, shift_go = '0;
  logic [`SOS_NCH-1:0] ev_hi = '0, ev_lo = '0, guard_wr = '0, ovl_clr = '0;
  logic [`SOS_NFLT-1:0] flt_clr = '0;
  logic [`SOS_SRC_W-1:0] fault_src = '0;
  logic key_wr = 1'b0;
  logic [`SOS_KEY_W-1:0] key_wdata = '0;
  sos_chan_prm_t prm_wdata = '0;
  sos_guard_t guard_wdata = '0;
  sos_fault_cfg_t [`SOS_NFLT-1:0] fault_cfg = '0;
  sos_drv_cfg_t [`SOS_NCH-1:0] drv_cfg = '0;
  logic [`SOS_NCH-1:0] high_side, low_side, pend, ovl_flag, shoot_seen;
  logic [`SOS_NFLT-1:0] live, sflag;
  sos_guard_t [`SOS_NCH-1:0] gps;
  int n_mismatch = 0;
  int cmp_count = 0;
  int ones;

  initial forever #25 clk_sys = ~clk_sys;

  sos_top dut_u (.clk_sys, .rst_n, .chan_enable, .chan_load, .prm_wr, .prm_wdata, .shift_go, .fault_src,
    .fault_cfg, .fault_latch_clear(flt_clr), .event_timer_high(ev_hi), .event_timer_low(ev_lo), .drv_cfg,
    .key_wr, .key_wdata, .guard_wr, .guard_wdata, .overlap_event_clear(ovl_clr), .high_side, .low_side,
    .commit_pending_flag(pend), .fault_live_state(live), .fault_sticky_flag(sflag),
    .overlap_event_flag(ovl_flag), .guarded_pair_settings(gps));
  sos_gate_drv gd_u (.clk_sys, .rst_n, .high_side, .low_side, .shoot_seen);

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : tick

  task automatic count_high(input int n);
    ones = 0;
    repeat (n) begin
      ones += int'(high_side[0] === 1'b1);
      @(posedge clk_sys);
    end
  endtask : count_high

  task automatic sync_rise;
    for (int k = 0; k < 200 && high_side[0] !== 1'b0; k++) @(posedge clk_sys);
    for (int k = 0; k < 200 && high_side[0] !== 1'b1; k++) @(posedge clk_sys);
  endtask : sync_rise

  task automatic wr_prm(input logic [`SOS_ON_W-1:0] on, input logic [15:0] sh = 16'h0000, input logic hd = 1'b0);
    @(posedge clk_sys);
    prm_wdata <= {on, 15'h000A, 16'h0014, sh, hd};
    prm_wr <= 4'h1;
    @(posedge clk_sys);
    prm_wr <= '0;
  endtask : wr_prm

  task automatic wr_guard(input logic [31:0] key, input sos_guard_t g, input logic [3:0] m = 4'h1);
    @(posedge clk_sys);
    key_wr <= 1'b1;
    key_wdata <= key;
    @(posedge clk_sys);
    key_wr <= 1'b0;
    guard_wr <= m;
    guard_wdata <= g;
    @(posedge clk_sys);
    guard_wr <= '0;
    tick(2);
  endtask : wr_guard

  task automatic pulse_fault(input int n = 10, input int b = 5);
    @(posedge clk_sys);
    fault_src[b] <= 1'b1;
    tick(n);
    fault_src[b] <= 1'b0;
    tick(12);
  endtask : pulse_fault

  task automatic step_run(input logic hd);
    chan_load <= 4'h0;
    wr_prm(19'h00060, 16'h0004, hd);
    chan_load <= 4'h1;
    tick(15);
    sync_rise();
    shift_go <= 4'h1;
    @(posedge clk_sys);
    shift_go <= 4'h0;
    sync_rise();
    count_high(20);
  endtask : step_run

  task automatic tally_and_finish;
    $display("summary n_mismatch %0d cmp_count %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : tally_and_finish

  initial begin
    #250000;
    n_mismatch++;
    tally_and_finish();
  end

  initial begin
    repeat (16) @(posedge clk_sys);
    rst_n <= 1'b1;
    tick(2);
    chk("pins after reset", 32'h0, {high_side, low_side, pend, ovl_flag});
    chk("flags after reset", 32'h0, {sflag, live, gps});
    drv_cfg[0] <= '{pair_sel: 3'h0, out_en: 1'b1, min_gap: 8'h02, hi_export: 1'b1, lo_export: 1'b1, default: '0};
    drv_cfg[1] <= '{out_en: 1'b1, hi_force_val: 1'b1, hi_force_sel: 1'b1, lo_force_sel: 1'b1,
      hi_export: 1'b1, lo_export: 1'b1, default: '0};
    drv_cfg[2] <= '{out_en: 1'b1, hi_force_val: 1'b1, lo_force_val: 1'b1, hi_force_sel: 1'b1,
      lo_force_sel: 1'b1, min_gap: 8'h01, hi_export: 1'b1, lo_export: 1'b1, default: '0};
    fault_cfg[0] <= '{en: 1'b1, src_sel: 7'h05, sticky: 1'b1, default: '0};
    wr_prm(19'h00048);
    @(posedge clk_sys);
    chan_enable <= 4'h1;
    count_high(20);
    chk("high ticks inside start delay", 32'h0, ones);
    tick(60);
    chk("forced pair", 32'h2, {high_side[1], low_side[1]});
    chk("both sides requested", 32'h4, {ovl_flag[2], high_side[2], low_side[2]});
    drv_cfg[2].lo_force_val <= 1'b0;
    ovl_clr <= 4'h4;
    @(posedge clk_sys);
    ovl_clr <= 4'h0;
    tick(4);
    chk("overlap flag after clear", 32'h2, {ovl_flag[2], high_side[2], low_side[2]});
    wr_guard(32'h0, 4'h8);
    chk("guard without key", 32'h0, gps[0]);
    wr_guard(`SOS_UNLOCK_KEY, 4'h8);
    chk("guard under key", 32'h8, gps[0]);
    drv_cfg[3] <= '{pair_sel: 3'h5, out_en: 1'b1, hi_export: 1'b1, lo_export: 1'b1, default: '0};
    ev_hi <= 4'h2;
    wr_guard(`SOS_UNLOCK_KEY, 4'h4, 4'h8);
    chk("swapped timer pair", 32'h1, {high_side[3], low_side[3]});
    ev_hi <= 4'h0;
    wr_guard(`SOS_UNLOCK_KEY, 4'h6, 4'h8);
    chk("swapped and flipped pair", 32'h2, {high_side[3], low_side[3]});
    sync_rise();
    count_high(160);
    chk("dithered high ticks", 32'd72, ones);
    wr_prm(19'h00060);
    sync_rise();
    count_high(160);
    chk("high ticks after shadow write", 32'd72, ones);
    sync_rise();
    chan_load <= 4'h1;
    tick(3);
    chk("pending after load", 32'h1, pend[0]);
    tick(12);
    chk("pending after transfer", 32'h0, pend[0]);
    sync_rise();
    count_high(160);
    chk("integer high ticks", 32'd96, ones);
    chan_load <= 4'h0;
    wr_prm(19'h00020);
    sync_rise();
    chan_load <= 4'h1;
    @(posedge clk_sys);
    chan_load <= 4'h0;
    tick(3);
    chk("pending after cancel", 32'h0, pend[0]);
    sync_rise();
    count_high(160);
    chk("high ticks after cancel", 32'd96, ones);
    drv_cfg[0].fault_gate <= 8'h01;
    pulse_fault();
    chk("sticky fault flag", 32'h1, sflag[0]);
    count_high(40);
    chk("high ticks under fault", 32'h0, {ones[30:0], low_side[0]});
    flt_clr <= 8'h01;
    @(posedge clk_sys);
    flt_clr <= 8'h00;
    tick(5);
    chk("fault flag after clear", 32'h0, sflag[0]);
    fault_cfg[0].sticky <= 1'b0;
    pulse_fault();
    chk("flag after passing fault", 32'h1, sflag[0]);
    sync_rise();
    count_high(160);
    chk("high ticks after passing fault", 32'd96, ones);
    fault_cfg[1] <= '{en: 1'b1, src_sel: 7'h09, filt_en: 1'b1, filt_width: 8'h06, default: '0};
    pulse_fault(3, 9);
    chk("flag after short glitch", 32'h0, sflag[1]);
    pulse_fault(12, 9);
    chk("flag and state after long fault", 32'h2, {sflag[1], live[1]});
    fault_cfg[1].flip <= 1'b1;
    tick(3);
    chk("flipped idle fault state", 32'h1, live[1]);
    step_run(1'b0);
    chk("stretched cycle high ticks", 32'd16, ones);
    step_run(1'b1);
    chk("half duty stretched high ticks", 32'd13, ones);
    chk("shoot-through at driver", 32'h0, shoot_seen);
    tally_and_finish();
  end
endmodule : tb_top
